// ==== rtl/codec_regs_defs.svh ====
// Register offsets, field positions and reset values of the codec regs
`ifndef CODEC_REGS_DEFS_SVH
`define CODEC_REGS_DEFS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define LOL_IDX          8'h2E
`define APE_IDX          8'h30
`define STAT_IDX         8'h34
`define LOL_ADDR         ({`LOL_IDX, 2'b00})
`define APE_ADDR         ({`APE_IDX, 2'b00})
`define STAT_ADDR        ({`STAT_IDX, 2'b00})

// ==========================================================================
// Line-out level register layout
`define LEVEL_W          5
`define RIGHT_LSB        8
`define LEFT_LSB         0
`define LEVEL_RST        5'h04

// ==========================================================================
// Analog power enables layout
`define APE_SPARE_BIT    15
`define APE_STEREO_BIT   14
`define APE_LPREG_BIT    13
`define APE_STARTUP_BIT  12
`define APE_CPUMP_BIT    11
`define APE_PLL_BIT      10
`define APE_SPARE_RST    1'h0
`define APE_STEREO_RST   1'h1
`define APE_LPREG_RST    1'h1
`define APE_STARTUP_RST  1'h1
`define APE_CPUMP_RST    1'h0
`define APE_PLL_RST      1'h0

// ==========================================================================
// Status register layout
`define STAT_CORE_EXT    0
`define STAT_PLL         1
`define STAT_MONO        2
`define STAT_LPREG_RISK  3
`define STAT_START_RISK  4

// ==========================================================================
// Line-out ground code scale, in millivolts
`define GND_BASE_MV      12'h320
`define GND_STEP_MV      12'h019

`endif

// ==== rtl/codec_regs_pkg.sv ====
// Types and helpers shared by the codec register bank
package codec_regs_pkg;
    `include "codec_regs_defs.svh"

    typedef logic [`LEVEL_W-1:0] level_type;
    typedef logic [15:0]         word_type;

    // Line-out ground code to millivolts, 25 mV per code from 800 mV
    function automatic logic [11:0] ground_mv(input logic [5:0] code);
        ground_mv = `GND_BASE_MV + 12'(`GND_STEP_MV * {6'h00, code});
    endfunction
endpackage

// ==== rtl/field_reg.sv ====
// Writable register field with constant reset value
`timescale 1ns/10ps
module field_reg #(
    parameter int             W   = 1,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         we,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    initial
    begin
        if (W < 1) $error("field_reg width must be positive");
    end

    // Load on write strobe only
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst) q <= RST;
        else if (we) q <= d;
    end
endmodule

// ==== rtl/sync3.sv ====
// Three-flop synchroniser for pin levels, change taken when stages agree
`timescale 1ns/10ps
module sync3 (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);
    logic s1Q;
    logic s2Q;
    logic s3Q;

    // First stage feeds only the second one
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1Q  <= 1'b0;
            s2Q  <= 1'b0;
            s3Q  <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            s1Q <= din;
            s2Q <= s1Q;
            s3Q <= s2Q;
            if (s2Q == s3Q) dout <= s3Q; // Filters one-cycle glitches
        end
    end
endmodule

// ==== rtl/lineout_level_and_analog_power_regs.sv ====
// Line-out level and analog power enable registers behind an APB slave
//
// Overview of operation
// - Each level code step is half a decibel, larger codes attenuate more.
// - Right line-out level is a five-bit RW field at 12:8, reset four.
// - Left level is a five-bit RW field at 4:0, reset four; 15:13, 7:5 zero.
// - The analog power register gathers the analog power-down controls; this block holds only bits 15:10 of it.
// - Only mic bias impedance and zero-cross enables power down elsewhere.
// - Bit 14, reset one, picks stereo or left mono, only while DAC is on.
// - Bit 13, reset one, runs low-power regulator; clear needs ext or primary.
// - Bit 12, reset one, runs start-up logic; clear only on external core.
// - Bit 11, reset zero, runs the charge pump; off when supplies are low; the output follows bit 11 alone, with no supply check.
// - Bit 10, reset zero, powers the PLL; clearing it turns the PLL off.
// - Line-out ground codes step 25 mV from 0.800 V at code zero.
`timescale 1ns/10ps
module lineout_level_and_analog_power_regs
    import codec_regs_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              dacPowerOn,
    input  wire logic              primaryRegulatorOn,
    input  wire logic              coreSupplyExternal,
    output logic      [4:0]        lineoutRightLevel,
    output logic      [4:0]        lineoutLeftLevel,
    output logic                   dacMonoMode,
    output logic                   lowpowerRegulatorOn,
    output logic                   startupCircuitOn,
    output logic                   chargePumpOn,
    output logic                   pllOn
);
    // ======================================================================
    // Elaboration checks
    initial
    begin
        if (ADDR_W < 10) $error("ADDR_W too small for the register map");
    end

    // ======================================================================
    // Bus decode
    logic              setupPhase;
    logic              writeDone;
    logic              hitLol;
    logic              hitApe;
    logic              hitStat;
    logic              hitAny;
    logic              wrLol;
    logic              wrApe;
    logic [ADDR_W-1:0] lolAddr;
    logic [ADDR_W-1:0] apeAddr;
    logic [ADDR_W-1:0] statAddr;

    assign lolAddr    = ADDR_W'(`LOL_ADDR);
    assign apeAddr    = ADDR_W'(`APE_ADDR);
    assign statAddr   = ADDR_W'(`STAT_ADDR);
    // Setup cycle; the answer is prepared here so access needs no wait
    assign setupPhase = psel && !penable;
    assign writeDone  = psel && penable && pready && pwrite;
    assign hitLol     = (paddr == lolAddr);
    assign hitApe     = (paddr == apeAddr);
    assign hitStat    = (paddr == statAddr);
    assign hitAny     = hitLol || hitApe || hitStat;
    assign wrLol      = writeDone && hitLol;
    assign wrApe      = writeDone && hitApe;

    // ======================================================================
    // Line-out level fields
    level_type rightQ;
    level_type leftQ;

    // Only the level bits are stored, reserved write data is dropped
    field_reg #(.W(`LEVEL_W), .RST(`LEVEL_RST)) rightField (
        .clk  (clk),
        .nrst (nrst),
        .we   (wrLol),
        .d    (pwdata[`RIGHT_LSB +: `LEVEL_W]),
        .q    (rightQ)
    );

    field_reg #(.W(`LEVEL_W), .RST(`LEVEL_RST)) leftField (
        .clk  (clk),
        .nrst (nrst),
        .we   (wrLol),
        .d    (pwdata[`LEFT_LSB +: `LEVEL_W]),
        .q    (leftQ)
    );

    // ======================================================================
    // Analog power enable bits, one field per control
    logic spareQ;
    logic stereoQ;
    logic lpregQ;
    logic startupQ;
    logic cpumpQ;
    logic pllQ;

    // Only bits 15:10 of the power-down word are held, one field each
    // Other power-down controls sit in other blocks, not here
    field_reg #(.W(1), .RST(`APE_SPARE_RST)) spareField (
        .clk  (clk),
        .nrst (nrst),
        .we   (wrApe),
        .d    (pwdata[`APE_SPARE_BIT]),
        .q    (spareQ)
    );

    field_reg #(.W(1), .RST(`APE_STEREO_RST)) stereoField (
        .clk  (clk),
        .nrst (nrst),
        .we   (wrApe),
        .d    (pwdata[`APE_STEREO_BIT]),
        .q    (stereoQ)
    );

    field_reg #(.W(1), .RST(`APE_LPREG_RST)) lpregField (
        .clk  (clk),
        .nrst (nrst),
        .we   (wrApe),
        .d    (pwdata[`APE_LPREG_BIT]),
        .q    (lpregQ)
    );

    field_reg #(.W(1), .RST(`APE_STARTUP_RST)) startupField (
        .clk  (clk),
        .nrst (nrst),
        .we   (wrApe),
        .d    (pwdata[`APE_STARTUP_BIT]),
        .q    (startupQ)
    );

    field_reg #(.W(1), .RST(`APE_CPUMP_RST)) cpumpField (
        .clk  (clk),
        .nrst (nrst),
        .we   (wrApe),
        .d    (pwdata[`APE_CPUMP_BIT]),
        .q    (cpumpQ)
    );

    field_reg #(.W(1), .RST(`APE_PLL_RST)) pllField (
        .clk  (clk),
        .nrst (nrst),
        .we   (wrApe),
        .d    (pwdata[`APE_PLL_BIT]),
        .q    (pllQ)
    );

    // ======================================================================
    // Supply strap from the pin
    logic coreExtSync;

    sync3 coreExtSyncer (
        .clk  (clk),
        .nrst (nrst),
        .din  (coreSupplyExternal),
        .dout (coreExtSync)
    );

    // ======================================================================
    // Outputs towards the analog blocks, registered one cycle after store
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lineoutRightLevel   <= `LEVEL_RST;
            lineoutLeftLevel    <= `LEVEL_RST;
            lowpowerRegulatorOn <= `APE_LPREG_RST;
            startupCircuitOn    <= `APE_STARTUP_RST;
            chargePumpOn        <= `APE_CPUMP_RST;
            pllOn               <= `APE_PLL_RST;
        end
        else
        begin
            lineoutRightLevel   <= rightQ;  // Half dB per code
            lineoutLeftLevel    <= leftQ;   // Half dB per code
            lowpowerRegulatorOn <= lpregQ;
            startupCircuitOn    <= startupQ;
            chargePumpOn        <= cpumpQ;
            pllOn               <= pllQ;    // Clear switches PLL off
        end
    end

    // Mono only counts while the DAC runs; otherwise the bit is inert
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst) dacMonoMode <= 1'b0;
        else dacMonoMode <= dacPowerOn && !stereoQ;
    end

    // ======================================================================
    // Status: flags low-power regulator off with no other core supply, or start-up off on internal core.
    // The device cannot stop the write, so it only reports the hazard.
    logic lpregRiskQ;
    logic startRiskQ;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lpregRiskQ <= 1'b0;
            startRiskQ <= 1'b0;
        end
        else
        begin
            lpregRiskQ <= !lpregQ && !coreExtSync
                          && !primaryRegulatorOn;
            startRiskQ <= !startupQ && !coreExtSync;
        end
    end

    // ======================================================================
    // Read data and answer, loaded in the setup cycle
    word_type readWord;

    always_comb
    begin
        readWord = 16'h0000;
        if (hitLol)
        begin
            // Reserved bits stay zero
            readWord[`RIGHT_LSB +: `LEVEL_W] = rightQ;
            readWord[`LEFT_LSB +: `LEVEL_W]  = leftQ;
        end
        else if (hitApe)
        begin
            readWord[`APE_SPARE_BIT]   = spareQ;
            readWord[`APE_STEREO_BIT]  = stereoQ;
            readWord[`APE_LPREG_BIT]   = lpregQ;
            readWord[`APE_STARTUP_BIT] = startupQ;
            readWord[`APE_CPUMP_BIT]   = cpumpQ;
            readWord[`APE_PLL_BIT]     = pllQ;
        end
        else if (hitStat)
        begin
            readWord[`STAT_CORE_EXT]   = coreExtSync;
            readWord[`STAT_PLL]        = pllOn;
            readWord[`STAT_MONO]       = dacMonoMode;
            readWord[`STAT_LPREG_RISK] = lpregRiskQ;
            readWord[`STAT_START_RISK] = startRiskQ;
        end
    end

    // Zero wait states: pready rises for the access cycle only
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= setupPhase;
            pslverr <= setupPhase && !hitAny;
            if (setupPhase && !pwrite) prdata <= {16'h0000, readWord};
        end
    end

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_ready_follows_setup;
        setupPhase |=> pready ##1 !pready;
    endproperty
    a_ready_follows_setup: assert property (p_ready_follows_setup)
        else $error("pready not a single access cycle after setup");

    property p_right_level;
        wrLol |=> ##1 lineoutRightLevel == $past(pwdata[12:8], 2);
    endproperty
    a_right_level: assert property (p_right_level)
        else $error("right level output does not follow write");

    property p_left_level;
        wrLol |=> ##1 lineoutLeftLevel == $past(pwdata[4:0], 2);
    endproperty
    a_left_level: assert property (p_left_level)
        else $error("left level output does not follow write");

    property p_reserved_zero;
        psel && penable && !pwrite && hitLol
            |-> prdata[31:13] == 19'h00000 && prdata[7:5] == 3'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved level bits read nonzero");

    property p_power_word;
        wrApe |=> ##1 chargePumpOn == $past(pwdata[11], 2)
            && lowpowerRegulatorOn == $past(pwdata[13], 2);
    endproperty
    a_power_word: assert property (p_power_word)
        else $error("power enables do not follow write");

    property p_mono_needs_dac;
        !dacPowerOn |=> !dacMonoMode;
    endproperty
    a_mono_needs_dac: assert property (p_mono_needs_dac)
        else $error("mono mode active while DAC is off");

    property p_pll_off;
        wrApe && !pwdata[10] |=> ##1 !pllOn;
    endproperty
    a_pll_off: assert property (p_pll_off)
        else $error("PLL stays on after clear");

    property p_lpreg_risk;
        !lowpowerRegulatorOn && !coreExtSync && !primaryRegulatorOn
            && $stable(primaryRegulatorOn) && $stable(coreExtSync)
            |-> lpregRiskQ;
    endproperty
    a_lpreg_risk: assert property (p_lpreg_risk)
        else $error("unsupplied core not flagged");

    property p_start_risk;
        startRiskQ |-> !$past(startupQ) && !$past(coreExtSync);
    endproperty
    a_start_risk: assert property (p_start_risk)
        else $error("start-up risk flag without cause");

    property p_slverr_unmapped;
        setupPhase && !hitAny |=> pslverr && pready;
    endproperty
    a_slverr_unmapped: assert property (p_slverr_unmapped)
        else $error("unmapped access not refused");

    c_level_write: cover property (wrLol);
    c_pll_on: cover property (wrApe && pwdata[10] ##2 pllOn);
    c_mono: cover property (dacMonoMode);
    c_unmapped: cover property (pslverr);
endmodule

// ==== verification/lineout_level_and_analog_power_regs_tb.sv ====
// Self-checking bench for the line-out level and analog power registers
`timescale 1ns/10ps
`include "codec_regs_defs.svh"
module lineout_level_and_analog_power_regs_tb;
    import codec_regs_pkg::*;

    // ======================================================================
    // Signals
    logic        clk;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        dacPowerOn;
    logic        primaryRegulatorOn;
    logic        coreSupplyExternal;
    level_type   rightLvl;
    level_type   leftLvl;
    logic        dacMonoMode;
    logic        lpReg;
    logic        startup;
    logic        cpump;
    logic        pllOn;
    int          badCount;
    int          numChecks;

    // Level writes and their read-back; reserved bits must drop out
    logic [31:0] lvlIn [4] = '{32'hFFFF_FFFF, 32'h0000_E0E0,
                               32'h0000_0F0F, 32'h0000_0619};
    logic [31:0] lvlExp [4] = '{32'h0000_1F1F, 32'h0000_0000,
                                32'h0000_0F0F, 32'h0000_0619};

    // ======================================================================
    // Device under test
    lineout_level_and_analog_power_regs #(
        .ADDR_W (10)
    ) lineout_level_and_analog_power_regs_i (
        .clk                 (clk),
        .nrst                (nrst),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .dacPowerOn          (dacPowerOn),
        .primaryRegulatorOn  (primaryRegulatorOn),
        .coreSupplyExternal  (coreSupplyExternal),
        .lineoutRightLevel   (rightLvl),
        .lineoutLeftLevel    (leftLvl),
        .dacMonoMode         (dacMonoMode),
        .lowpowerRegulatorOn (lpReg),
        .startupCircuitOn    (startup),
        .chargePumpOn        (cpump),
        .pllOn               (pllOn)
    );

    // ======================================================================
    // Clock, 50 ns period
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ======================================================================
    // Checking and reporting
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        begin
            numChecks++;
            if (got !== exp)
            begin
                badCount++;
                $display("[FAIL] %0t %s got %h want %h", $time, what, got,
                         exp);
            end
        end
    endtask

    task automatic wrap_up();
        begin
            if (badCount == 0 && numChecks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // Mirror pins: right, left, then mono, lpreg, startup, cpump, pll
    task automatic pins(input logic [14:0] exp);
        begin
            chk({17'h0, rightLvl, leftLvl, dacMonoMode, lpReg, startup,
                 cpump, pllOn}, {17'h0, exp}, "pins");
        end
    endtask

    // One APB transfer; keep leaves psel up so the next setup follows at once
    task automatic xfer(input logic w, input logic [9:0] a,
                        input logic [31:0] d, input logic [31:0] e,
                        input logic err, input logic keep);
        int n;
        begin
            psel   <= 1'b1;
            pwrite <= w;
            paddr  <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            for (n = 0; n < 16; n++)
            begin
                @(posedge clk);
                if (pready === 1'b1)
                    break;
            end
            if (n == 16)
            begin
                badCount++;
                $display("[FAIL] %0t no pready", $time);
                wrap_up();
            end
            chk({31'h0, pslverr}, {31'h0, err}, "pslverr");
            if (!w)
                chk(prdata, e, "prdata");
            penable <= 1'b0;
            if (!keep)
            begin
                psel <= 1'b0;
                @(posedge clk);
            end
        end
    endtask

    // ======================================================================
    // Main sequence
    initial
    begin
        nrst               = 1'b0;
        psel               = 1'b0;
        penable            = 1'b0;
        pwrite             = 1'b0;
        paddr              = 10'h000;
        pwdata             = 32'h0000_0000;
        dacPowerOn         = 1'b0;
        primaryRegulatorOn = 1'b0;
        coreSupplyExternal = 1'b0;
        badCount           = 0;
        numChecks          = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // Reset state, read back to back
        pins({5'h04, 5'h04, 5'h0C});
        xfer(1'b0, `LOL_ADDR, '0, 32'h0404, 1'b0, 1'b1);
        xfer(1'b0, `APE_ADDR, '0, 32'h7000, 1'b0, 1'b0);
        // Level fields: all-ones, reserved-only, suggested codes
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b1, `LOL_ADDR, lvlIn[i], '0, 1'b0, 1'b1);
            xfer(1'b0, `LOL_ADDR, '0, lvlExp[i], 1'b0, 1'b0);
            @(posedge clk);
            pins({lvlExp[i][12:8], lvlExp[i][4:0], 5'h0C});
        end
        // Power bits all set, then all cleared; bits 9:0 are not held
        xfer(1'b1, `APE_ADDR, 32'hFFFF_FFFF, '0, 1'b0, 1'b1);
        xfer(1'b0, `APE_ADDR, '0, 32'h0000_FC00, 1'b0, 1'b0);
        @(posedge clk);
        pins({5'h06, 5'h19, 5'h0F});
        xfer(1'b1, `APE_ADDR, 32'h0000_0000, '0, 1'b0, 1'b1);
        xfer(1'b0, `APE_ADDR, '0, 32'h0000_0000, 1'b0, 1'b0);
        @(posedge clk);
        pins({5'h06, 5'h19, 5'h00});
        // Mono applies only once the DAC is powered
        dacPowerOn <= 1'b1;
        repeat (3) @(posedge clk);
        pins({5'h06, 5'h19, 5'h10});
        // Status with regulator and start-up bits cleared and no safe supply
        xfer(1'b0, `STAT_ADDR, '0, 32'h0000_001C, 1'b0, 1'b0);
        // Long wait covers the pin synchroniser latency
        primaryRegulatorOn <= 1'b1;
        coreSupplyExternal <= 1'b1;
        repeat (8) @(posedge clk);
        xfer(1'b0, `STAT_ADDR, '0, 32'h0000_0005, 1'b0, 1'b0);
        xfer(1'b1, `STAT_ADDR, 32'hFFFF_FFFF, '0, 1'b0, 1'b1);
        xfer(1'b0, `STAT_ADDR, '0, 32'h0000_0005, 1'b0, 1'b0);
        // Stereo with PLL on, external supply gone again
        coreSupplyExternal <= 1'b0;
        xfer(1'b1, `APE_ADDR, 32'h0000_4400, '0, 1'b0, 1'b0);
        repeat (8) @(posedge clk);
        pins({5'h06, 5'h19, 5'h01});
        xfer(1'b0, `STAT_ADDR, '0, 32'h0000_0012, 1'b0, 1'b0);
        // Unmapped and unaligned places refuse and leave levels alone
        xfer(1'b1, 10'h100, 32'h0000_1F1F, '0, 1'b1, 1'b1);
        xfer(1'b1, 10'h0B9, 32'h0000_1F1F, '0, 1'b1, 1'b1);
        xfer(1'b0, 10'h0BA, '0, 32'h0000_0000, 1'b1, 1'b1);
        xfer(1'b0, `LOL_ADDR, '0, 32'h0000_0619, 1'b0, 1'b0);
        wrap_up();
    end
endmodule
